/* File: include/msq_pkg.sv */
package msq_pkg;

  // clock rate of the register and sequencer domain
  localparam int CLK_HZ          = 100_000_000;
  localparam int CYC_PER_US      = CLK_HZ / 1_000_000;

  // conversion timing, in microseconds as documented
  localparam int VOLT_CONV_US    = 12_200;
  localparam int TEMP_CONV_US    = 3_600;
  localparam int LP_ROUND_US     = 728_000;
  localparam int VOLT_CONV_CYC   = VOLT_CONV_US * CYC_PER_US;
  localparam int TEMP_CONV_CYC   = TEMP_CONV_US * CYC_PER_US;
  localparam int LP_ROUND_CYC    = LP_ROUND_US * CYC_PER_US;

  // register offsets
  localparam logic [7:0] REG_CONFIG      = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h01;
  localparam logic [7:0] REG_RATE        = 8'h07;
  localparam logic [7:0] REG_DISABLE     = 8'h08;
  localparam logic [7:0] REG_ONESHOT     = 8'h09;
  localparam logic [7:0] REG_SLEEP       = 8'h0A;
  localparam logic [7:0] REG_RESULT_BASE = 8'h20;
  localparam logic [7:0] REG_RESULT_LAST = 8'h27;
  localparam logic [7:0] REG_LIMIT_BASE  = 8'h2A;
  localparam logic [7:0] REG_LIMIT_LAST  = 8'h39;

  // field positions
  localparam int CFG_RUN_BIT     = 0;
  localparam int CFG_HOLD_BIT    = 3;
  localparam int CFG_INIT_BIT    = 7;
  localparam int RATE_CONT_BIT   = 0;
  localparam int SLEEP_DEEP_BIT  = 0;

  // reset values
  localparam logic [7:0] CFG_RESET     = 8'h08;
  localparam logic [7:0] RATE_RESET    = 8'h00;
  localparam logic [7:0] DISABLE_RESET = 8'h00;
  localparam logic [7:0] SLEEP_RESET   = 8'h00;

  // channel layout and bus address
  localparam logic [2:0] TEMP_CH       = 3'h7;
  localparam logic [6:0] BUS_ADDR_BASE = 7'h1D;

  typedef enum logic [1:0] {
    SEQ_OFF  = 2'b00,
    SEQ_DEEP = 2'b01,
    SEQ_CONV = 2'b10,
    SEQ_HOLD = 2'b11
  } msq_seq_state_type;

  typedef enum logic [2:0] {
    LNK_ADDR  = 3'b000,
    LNK_PTR   = 3'b001,
    LNK_WDATA = 3'b010,
    LNK_RDATA = 3'b011,
    LNK_IDLE  = 3'b100
  } msq_lnk_state_type;

endpackage : msq_pkg

/* File: rtl/msq_sequencer.sv */
`timescale 1ns/1ps
module msq_sequencer
  import msq_pkg::*;
#(
  parameter int VOLT_CYC = VOLT_CONV_CYC,
  parameter int TEMP_CYC = TEMP_CONV_CYC,
  parameter int LP_CYC   = LP_ROUND_CYC
)
(
  // system
  input  wire logic        clk,
  input  wire logic        reset_n,
  // serial link
  input  wire logic        scl_clk,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // address straps, 0 low, 1 mid, 2 high
  input  wire logic [1:0]  addr_strap_lo,
  input  wire logic [1:0]  addr_strap_hi,
  // converter
  input  wire logic [11:0] adc_value,
  output logic [2:0]       adc_channel,
  output logic             adc_start,
  // status
  output logic             converting,
  output logic             deep_sleep,
  output logic [7:0]       limit_alarm
);

  logic                    rst_n_q1;
  logic                    rst_n_q;
  logic [7:0]              cfg_q;
  logic [7:0]              rate_q;
  logic [7:0]              dis_q;
  logic [7:0]              sleep_q;
  logic [7:0]              limit_q [16];
  logic [15:0]             result_q [8];
  logic [7:0]              status_q;
  msq_seq_state_type       seq_q;
  logic [2:0]              ch_q;
  logic [26:0]             tmr_q;
  logic [26:0]             lp_tmr_q;
  logic                    oneshot_run_q;
  logic [2:0]              wr_sync_q;
  logic [2:0]              start_sync_q;
  logic [2:0]              stop_sync_q;
  logic                    busy_q;
  logic [1:0]              strap_lo_q1;
  logic [1:0]              strap_lo_q2;
  logic [1:0]              strap_hi_q1;
  logic [1:0]              strap_hi_q2;
  logic [1:0]              strap_cnt_q;
  logic [6:0]              bus_addr_q;
  // link domain
  logic                    start_tgl_q;
  logic                    stop_tgl_q;
  logic                    start_seen_q;
  msq_lnk_state_type       lnk_q;
  logic [3:0]              cnt_q;
  logic [7:0]              shift_q;
  logic [7:0]              ptr_q;
  logic                    rd_lo_q;
  logic                    ack_q;
  logic [7:0]              wr_addr_q;
  logic [7:0]              wr_data_q;
  logic                    wr_tgl_q;
  logic                    sda_oe_q;
  logic                    sda_o_q;
  logic [7:0]              rd_byte;
  logic [7:0]              rx_byte;
  logic                    new_start;
  logic                    wr_evt;
  logic                    run;
  logic                    oneshot_req;
  logic [3:0]              first_ch;
  logic [3:0]              next_ch;
  logic [7:0]              val8;
  logic                    out_of_range;

  // first enabled channel at or above from, 8 when none
  function automatic logic [3:0] find_ch(input logic [3:0] from, input logic [7:0] dis);
    logic [3:0] found;
    found = 4'h8;
    for (int i = 7; i >= 0; i--)
    begin
      if ((4'(i) >= from) && !dis[i])
        found = 4'(i);
    end
    return found;
  endfunction : find_ch

  function automatic logic [26:0] conv_len(input logic [3:0] ch);
    return (ch[2:0] == TEMP_CH) ? 27'(TEMP_CYC) : 27'(VOLT_CYC);
  endfunction : conv_len

  // reset release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_n_q1 <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_n_q1 <= 1'b1;
      rst_n_q  <= rst_n_q1;
    end
  end

  // straps sampled once after reset release
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      strap_lo_q1  <= 2'h0;
      strap_lo_q2  <= 2'h0;
      strap_hi_q1  <= 2'h0;
      strap_hi_q2  <= 2'h0;
      strap_cnt_q  <= 2'h0;
      bus_addr_q   <= BUS_ADDR_BASE;
    end
    else
    begin
      strap_lo_q1  <= addr_strap_lo;
      strap_lo_q2  <= strap_lo_q1;
      strap_hi_q1  <= addr_strap_hi;
      strap_hi_q2  <= strap_hi_q1;
      if (strap_cnt_q != 2'h3)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      // freeze only once the pins have passed both sync stages
      if (strap_cnt_q == 2'h2)
        bus_addr_q <= BUS_ADDR_BASE + 7'(3 * (strap_hi_q2 > 2'h2 ? 2'h2 : strap_hi_q2))
                      + 7'(strap_lo_q2 > 2'h2 ? 2'h2 : strap_lo_q2);
    end
  end

  // start and stop conditions, clocked by the data line itself
  always_ff @(negedge sda_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      start_tgl_q <= 1'b0;
    else if (scl_clk)
      start_tgl_q <= ~start_tgl_q;
  end

  always_ff @(posedge sda_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      stop_tgl_q <= 1'b0;
    else if (scl_clk)
      stop_tgl_q <= ~stop_tgl_q;
  end

  // events into the system domain
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_sync_q    <= 3'h0;
      start_sync_q <= 3'h0;
      stop_sync_q  <= 3'h0;
      busy_q       <= 1'b0;
    end
    else
    begin
      wr_sync_q    <= {wr_sync_q[1:0], wr_tgl_q};
      start_sync_q <= {start_sync_q[1:0], start_tgl_q};
      stop_sync_q  <= {stop_sync_q[1:0], stop_tgl_q};
      if (start_sync_q[2] != start_sync_q[1])
        busy_q <= 1'b1;
      else if (stop_sync_q[2] != stop_sync_q[1])
        busy_q <= 1'b0;
    end
  end

  assign wr_evt      = wr_sync_q[2] != wr_sync_q[1];
  assign run         = cfg_q[CFG_RUN_BIT] && !cfg_q[CFG_HOLD_BIT];
  assign oneshot_req = wr_evt && (wr_addr_q == REG_ONESHOT) && !run;

  // register writes from the link
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cfg_q   <= CFG_RESET;
      rate_q  <= RATE_RESET;
      dis_q   <= DISABLE_RESET;
      sleep_q <= SLEEP_RESET;
      for (int i = 0; i < 16; i++)
        limit_q[i] <= 8'h00;
    end
    else if (wr_evt)
    begin
      if (wr_addr_q == REG_CONFIG && wr_data_q[CFG_INIT_BIT])
      begin
        cfg_q   <= CFG_RESET;
        rate_q  <= RATE_RESET;
        dis_q   <= DISABLE_RESET;
        sleep_q <= SLEEP_RESET;
      end
      else if (wr_addr_q == REG_CONFIG)
        cfg_q <= wr_data_q;
      else if (wr_addr_q == REG_RATE)
        rate_q <= wr_data_q;
      else if (wr_addr_q == REG_DISABLE)
        dis_q <= wr_data_q;
      else if (wr_addr_q == REG_SLEEP)
        sleep_q <= wr_data_q;
      else if (wr_addr_q >= REG_LIMIT_BASE && wr_addr_q <= REG_LIMIT_LAST)
        limit_q[4'(wr_addr_q - REG_LIMIT_BASE)] <= wr_data_q;
    end
  end

  assign first_ch     = find_ch(4'h0, dis_q);
  assign next_ch      = find_ch({1'b0, ch_q} + 4'h1, dis_q);
  assign val8         = adc_value[11:4];
  assign out_of_range = (ch_q == TEMP_CH) ? (val8 > limit_q[14])
                      : (val8 > limit_q[{ch_q, 1'b0}]) || (val8 <= limit_q[{ch_q, 1'b1}]);

  // conversion sequencer
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      seq_q         <= SEQ_OFF;
      ch_q          <= 3'h0;
      tmr_q         <= 27'h0;
      lp_tmr_q      <= 27'h0;
      oneshot_run_q <= 1'b0;
      adc_start     <= 1'b0;
      adc_channel   <= 3'h0;
    end
    else
    begin
      adc_start <= 1'b0;
      if (lp_tmr_q != 27'h0)
        lp_tmr_q <= lp_tmr_q - 27'h1;
      case (seq_q)
        SEQ_OFF, SEQ_DEEP:
        begin
          if (seq_q == SEQ_DEEP && !sleep_q[SLEEP_DEEP_BIT])
            seq_q <= SEQ_OFF;
          else if (seq_q == SEQ_OFF && sleep_q[SLEEP_DEEP_BIT] && !run)
            seq_q <= SEQ_DEEP;
          else if (oneshot_req || (seq_q == SEQ_OFF && run
                   && (rate_q[RATE_CONT_BIT] || lp_tmr_q == 27'h0)))
          begin
            oneshot_run_q <= oneshot_req;
            if (!rate_q[RATE_CONT_BIT])
              lp_tmr_q <= 27'(LP_CYC - 1); // start edge counts as the first cycle
            if (first_ch != 4'h8)
            begin
              ch_q      <= first_ch[2:0];
              adc_channel <= first_ch[2:0];
              tmr_q     <= conv_len(first_ch);
              adc_start <= 1'b1;
              seq_q     <= SEQ_CONV;
            end
          end
        end
        SEQ_CONV, SEQ_HOLD:
        begin
          if (!run && !oneshot_run_q)
            seq_q <= SEQ_OFF;
          else if (seq_q == SEQ_CONV && tmr_q != 27'h1)
            tmr_q <= tmr_q - 27'h1;
          else if (busy_q)
            seq_q <= SEQ_HOLD;
          else if (next_ch != 4'h8)
          begin
            ch_q      <= next_ch[2:0];
            adc_channel <= next_ch[2:0];
            tmr_q     <= conv_len(next_ch);
            adc_start <= 1'b1;
            seq_q     <= SEQ_CONV;
          end
          else if (run && !oneshot_run_q && rate_q[RATE_CONT_BIT] && first_ch != 4'h8)
          begin
            // wrap straight to the first channel so continuous mode never idles
            ch_q        <= first_ch[2:0];
            adc_channel <= first_ch[2:0];
            tmr_q       <= conv_len(first_ch);
            adc_start   <= 1'b1;
            seq_q       <= SEQ_CONV;
          end
          else
            seq_q <= SEQ_OFF;
        end
        default:
          seq_q <= SEQ_OFF;
      endcase
    end
  end

  // results and comparison flags, written only with the bus idle
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (int i = 0; i < 8; i++)
        result_q[i] <= 16'h0000;
      status_q <= 8'h00;
    end
    else if ((seq_q == SEQ_HOLD || (seq_q == SEQ_CONV && tmr_q == 27'h1)) && !busy_q
             && (run || oneshot_run_q))
    begin
      result_q[ch_q] <= (ch_q == TEMP_CH) ? {adc_value[11:3], 7'h00} : {adc_value, 4'h0};
      status_q[ch_q] <= out_of_range;
    end
  end

  // outputs of the system domain
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      converting  <= 1'b0;
      deep_sleep  <= 1'b0;
      limit_alarm <= 8'h00;
    end
    else
    begin
      converting  <= seq_q == SEQ_CONV || seq_q == SEQ_HOLD;
      deep_sleep  <= seq_q == SEQ_DEEP;
      limit_alarm <= status_q;
    end
  end

  // read data; system registers cannot change mid-transfer since results wait for the
  // bus and every other write comes from this link, so the link reads them directly
  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr_q >= REG_RESULT_BASE && ptr_q <= REG_RESULT_LAST)
      rd_byte = rd_lo_q ? result_q[3'(ptr_q - REG_RESULT_BASE)][7:0]
                        : result_q[3'(ptr_q - REG_RESULT_BASE)][15:8];
    else if (ptr_q >= REG_LIMIT_BASE && ptr_q <= REG_LIMIT_LAST)
      rd_byte = limit_q[4'(ptr_q - REG_LIMIT_BASE)];
    else
    begin
      case (ptr_q)
        REG_CONFIG:  rd_byte = cfg_q;
        REG_STATUS:  rd_byte = status_q;
        REG_RATE:    rd_byte = rate_q;
        REG_DISABLE: rd_byte = dis_q;
        REG_SLEEP:   rd_byte = sleep_q;
        REG_ONESHOT: rd_byte = 8'h00;
        default:     rd_byte = 8'h00;
      endcase
    end
  end

  assign new_start = start_tgl_q != start_seen_q;
  assign rx_byte   = {shift_q[6:0], sda_i};

  // link receive side, sampled on the rising clock edge
  always_ff @(posedge scl_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      start_seen_q <= 1'b0;
      lnk_q        <= LNK_IDLE;
      cnt_q        <= 4'h0;
      shift_q      <= 8'h00;
      ptr_q        <= 8'h00;
      rd_lo_q      <= 1'b0;
      ack_q        <= 1'b0;
      wr_addr_q    <= 8'h00;
      wr_data_q    <= 8'h00;
      wr_tgl_q     <= 1'b0;
    end
    else
    begin
      start_seen_q <= start_tgl_q;
      if (new_start)
      begin
        lnk_q   <= LNK_ADDR;
        cnt_q   <= 4'h1;
        shift_q <= {7'h00, sda_i};
        ack_q   <= 1'b0;
        rd_lo_q <= 1'b0;
      end
      else if (lnk_q != LNK_IDLE && cnt_q == 4'h8)
      begin
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        // ack_q high marks the address byte's own ack, which must not advance the pointer
        if (lnk_q == LNK_RDATA && !ack_q && sda_i)
          lnk_q <= LNK_IDLE;
        else if (lnk_q == LNK_RDATA && !ack_q && ptr_q >= REG_RESULT_BASE && ptr_q <= REG_RESULT_LAST && !rd_lo_q)
          rd_lo_q <= 1'b1;
        else if (lnk_q == LNK_RDATA && !ack_q)
        begin
          rd_lo_q <= 1'b0;
          ptr_q   <= ptr_q + 8'h01;
        end
      end
      else if (lnk_q != LNK_IDLE)
      begin
        shift_q <= rx_byte;
        cnt_q   <= cnt_q + 4'h1;
        if (cnt_q == 4'h7)
        begin
          case (lnk_q)
            LNK_ADDR:
            begin
              ack_q <= rx_byte[7:1] == bus_addr_q;
              if (rx_byte[7:1] != bus_addr_q)
                lnk_q <= LNK_IDLE;
              else
                lnk_q <= rx_byte[0] ? LNK_RDATA : LNK_PTR;
            end
            LNK_PTR:
            begin
              ptr_q   <= rx_byte;
              rd_lo_q <= 1'b0;
              ack_q   <= 1'b1;
              lnk_q   <= LNK_WDATA;
            end
            LNK_WDATA:
            begin
              wr_addr_q <= ptr_q;
              wr_data_q <= rx_byte;
              wr_tgl_q  <= ~wr_tgl_q;
              ptr_q     <= ptr_q + 8'h01;
              ack_q     <= 1'b1;
            end
            default:
              ack_q <= 1'b0;
          endcase
        end
      end
    end
  end

  // link drive side, changes on the falling clock edge; open drain, pull low only
  always_ff @(negedge scl_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sda_oe_q <= 1'b0;
      sda_o_q  <= 1'b0;
    end
    else
    begin
      sda_o_q <= 1'b0;
      if (lnk_q == LNK_IDLE)
        sda_oe_q <= 1'b0;
      else if (cnt_q == 4'h8)
        sda_oe_q <= ack_q;
      else if (lnk_q == LNK_RDATA)
        sda_oe_q <= ~rd_byte[~cnt_q[2:0]];
      else
        sda_oe_q <= 1'b0;
    end
  end

  assign sda_oe = sda_oe_q;
  assign sda_o  = sda_o_q;

endmodule : msq_sequencer

/* File: bench/msq_sequencer_properties.sv */
`timescale 1ns/1ps
module msq_sequencer_properties
  import msq_pkg::*;
#(
  parameter int VOLT_CYC = VOLT_CONV_CYC,
  parameter int TEMP_CYC = TEMP_CONV_CYC
)
(
  // system
  input wire logic       clk,
  input wire logic       reset_n,
  // link
  input wire logic       scl_clk,
  input wire logic       sda_i,
  input wire logic       sda_oe,
  // converter and status
  input wire logic [2:0] adc_channel,
  input wire logic       adc_start,
  input wire logic       converting,
  input wire logic       deep_sleep,
  input wire logic [7:0] limit_alarm
);
  int         since_q;
  logic [2:0] last_q;
  logic       seen_q;
  logic       scl_q;
  logic       sda_q;
  logic       busy_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // cycles since the last conversion start, saturating to stay cheap
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      since_q <= 0;
      last_q  <= 3'h0;
      seen_q  <= 1'b0;
    end
    else if (adc_start)
    begin
      since_q <= 1;
      last_q  <= adc_channel;
      seen_q  <= 1'b1;
    end
    else if (since_q < 100000)
      since_q <= since_q + 1;
  end

  // frame tracking: sda moving while scl is high is start or stop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      busy_q <= 1'b0;
    end
    else
    begin
      scl_q <= scl_clk;
      sda_q <= sda_i;
      if (scl_clk && scl_q && sda_q != sda_i)
        busy_q <= !sda_i;
    end
  end

  property p_gap;
    adc_start && seen_q |-> since_q >= ((last_q == TEMP_CH) ? TEMP_CYC : VOLT_CYC);
  endproperty
  a_gap: assert property (p_gap) else $error("conversion cut short");
  property p_pulse;
    adc_start |=> !adc_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_conv;
    adc_start |=> converting;
  endproperty
  a_conv: assert property (p_conv) else $error("start without busy flag");
  property p_rise;
    $rose(converting) |-> adc_start || $past(adc_start);
  endproperty
  a_rise: assert property (p_rise) else $error("busy without a start");
  property p_deep;
    $rose(deep_sleep) |-> !converting;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep while converting");
  property p_alarm;
    $changed(limit_alarm) |-> converting || $past(converting);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm moved outside a pass");
  property p_oe_frame;
    sda_oe |-> busy_q;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("data line pulled outside a frame");
  property p_oe_scl;
    $changed(sda_oe) |-> !scl_clk;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("data line moved while clock high");

  c_temp: cover property (adc_start && adc_channel == TEMP_CH);
  c_deep: cover property ($rose(deep_sleep));
  c_ack: cover property ($rose(sda_oe));
endmodule : msq_sequencer_properties

bind msq_sequencer msq_sequencer_properties #(
  .VOLT_CYC(VOLT_CYC),
  .TEMP_CYC(TEMP_CYC)
) i_props (
  .clk(clk), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda_i), .sda_oe(sda_oe),
  .adc_channel(adc_channel), .adc_start(adc_start), .converting(converting),
  .deep_sleep(deep_sleep), .limit_alarm(limit_alarm)
);

/* File: bench/msq_host_model.sv */
`timescale 1ns/1ps
module msq_host_model
(
  // two-wire link
  output logic      scl_clk,
  output logic      sda_i,
  input  wire logic sda_oe
);
  logic pull_low;

  // pull-up on the wire: released means high, either side may pull low
  assign sda_i = !(pull_low || sda_oe);

  initial
  begin
    scl_clk  = 1'b1;
    pull_low = 1'b0;
  end

  // data moves only in the low phase; clock stands high between frames
  task automatic bit_out(input logic b);
    #8 pull_low = !b;
    #24 scl_clk = 1'b1;
    #32 scl_clk = 1'b0;
  endtask : bit_out

  task automatic bit_in(output logic b);
    #8 pull_low = 1'b0;
    #24 scl_clk = 1'b1;
    #1 b = sda_i;
    #31 scl_clk = 1'b0;
  endtask : bit_in

  task automatic start();
    if (!scl_clk)
    begin
      #8 pull_low = 1'b0;
      #24 scl_clk = 1'b1;
    end
    #16 pull_low = 1'b1;
    #16 scl_clk = 1'b0;
  endtask : start

  task automatic stop();
    #8 pull_low = 1'b1;
    #24 scl_clk = 1'b1;
    #16 pull_low = 1'b0;
    #16;
  endtask : stop

  task automatic put(input logic [7:0] d, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(x);
    ack = !x;
  endtask : put

  task automatic get(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(last);
  endtask : get

  task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic rd, input logic [7:0] wd,
                      input int nrd, output logic [15:0] rdat, output logic ack);
    logic       a;
    logic [7:0] b;
    rdat = 16'h0000;
    start();
    put({dev, 1'b0}, ack);
    put(ptr, a);
    ack = ack & a;
    if (rd)
    begin
      start();
      put({dev, 1'b1}, a);
      ack = ack & a;
      for (int i = 0; i < nrd; i++)
      begin
        get(b, i == nrd - 1);
        rdat = {rdat[7:0], b};
      end
    end
    else
    begin
      put(wd, a);
      ack = ack & a;
    end
    stop();
  endtask : xfer
endmodule : msq_host_model

/* File: bench/msq_sequencer_tb.sv */
`timescale 1ns/1ps
module msq_sequencer_tb
  import msq_pkg::*;
;
  localparam int         VC  = 20;
  localparam int         TC  = 8;
  localparam int         LC  = 400;
  localparam int         NEN = 4;
  localparam logic [7:0] DIS = 8'h6C;
  localparam logic [6:0] DEV = BUS_ADDR_BASE + 7'h07;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] salt = 8'h01;
  wire        scl_clk, sda_i, sda_o, sda_oe, adc_start, converting, deep_sleep;
  wire [2:0]  adc_channel;
  wire [7:0]  limit_alarm;
  int         n_errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         st_t[$];
  logic [2:0] st_ch[$];

  msq_sequencer #(.VOLT_CYC(VC), .TEMP_CYC(TC), .LP_CYC(LC)) i_dut (
    .clk(clk), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_lo(2'h1), .addr_strap_hi(2'h2), .adc_value({salt, 1'b0, adc_channel}),
    .adc_channel(adc_channel), .adc_start(adc_start), .converting(converting),
    .deep_sleep(deep_sleep), .limit_alarm(limit_alarm)
  );
  msq_host_model i_host (.scl_clk(scl_clk), .sda_i(sda_i), .sda_oe(sda_oe));

  always #5 clk = !clk;

  // sampled mid-cycle so the start pulse is never read in its launching time step
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1)
    begin
      st_t.push_back(cyc);
      st_ch.push_back(adc_channel);
    end
  end

  function automatic logic [15:0] res(input logic [2:0] c, input logic [7:0] s);
    return (c == TEMP_CH) ? {s, 1'b0, 7'h00} : {s, 1'b0, c, 4'h0};
  endfunction : res

  function automatic int dur(input logic [2:0] c);
    return (c == TEMP_CH) ? TC : VC;
  endfunction : dur

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report();
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // keeps host calls off the clock edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [15:0] r;
    logic        a;
    i_host.xfer(DEV, p, 1'b0, d, 1, r, a);
    chk("write acknowledge", 1, a);
  endtask : wr

  task automatic rd(input logic [7:0] p, input int n, input logic [15:0] e);
    logic [15:0] r;
    logic        a;
    i_host.xfer(DEV, p, 1'b1, 8'h00, n, r, a);
    chk("read acknowledge", 1, a);
    chk($sformatf("register %h", p), e, r);
  endtask : rd

  task automatic wait_idle();
    for (int i = 0; i < 3000 && converting !== 1'b0; i++)
      cycles(1);
    cycles(4);
    chk("converting", 0, converting);
  endtask : wait_idle

  task automatic check_pass(input int m, input int n);
    int k;
    int c;
    k = 0;
    c = 0;
    while (k < n)
    begin
      if (!DIS[c])
      begin
        chk("channel", c, st_ch[m + k]);
        if (k > 0)
          chk("conversion time", dur(st_ch[m + k - 1]), st_t[m + k] - st_t[m + k - 1]);
        k++;
      end
      c = (c + 1) % 8;
    end
  endtask : check_pass

  initial
  begin
    #500_000;
    n_errors++;
    final_report();
  end

  initial
  begin
    logic [15:0] r;
    logic        a;
    int          m;
    int          lows;
    int          ft[$];
    cycles(8);
    reset_n = 1'b1;
    cycles(14);
    rd(REG_CONFIG, 1, CFG_RESET);
    rd(REG_RATE, 1, RATE_RESET);
    rd(REG_DISABLE, 1, DISABLE_RESET);
    rd(REG_SLEEP, 1, SLEEP_RESET);
    rd(REG_ONESHOT, 1, 0);
    chk("data out level", 0, sda_o);
    i_host.xfer(BUS_ADDR_BASE + 7'h06, REG_CONFIG, 1'b1, 8'h00, 1, r, a);
    chk("foreign address ack", 0, a);
    wr(REG_CONFIG, 8'h00);
    wr(REG_DISABLE, DIS);
    wr(REG_LIMIT_BASE + 8'h01, 8'hFF);
    m = st_t.size();
    wr(REG_ONESHOT, 8'hA5);
    wait_idle();
    cycles(100);
    chk("one-shot starts", m + NEN, st_t.size());
    check_pass(m, NEN);
    chk("low alarm", 1, limit_alarm[0]);
    for (int c = 0; c < 8; c++)
      if (!DIS[c])
        rd(REG_RESULT_BASE + 8'(c), 2, res(3'(c), 8'h01));
    rd(REG_ONESHOT, 1, 0);
    // a read that covers the end of the pass must still see the old value
    cycles(1);
    salt = 8'h02;
    wr(REG_ONESHOT, 8'h5A);
    rd(REG_RESULT_BASE + 8'h07, 2, res(TEMP_CH, 8'h01));
    wait_idle();
    rd(REG_RESULT_BASE + 8'h07, 2, res(TEMP_CH, 8'h02));
    wr(REG_SLEEP, 8'h01);
    cycles(4);
    chk("deep sleep", 1, deep_sleep);
    salt = 8'h03;
    m = st_t.size();
    wr(REG_ONESHOT, 8'hFF);
    wait_idle();
    check_pass(m, NEN);
    chk("deep sleep", 1, deep_sleep);
    rd(REG_RESULT_BASE + 8'h01, 2, res(3'h1, 8'h03));
    wr(REG_SLEEP, 8'h00);
    cycles(4);
    chk("deep sleep", 0, deep_sleep);
    wr(REG_RATE, 8'h01);
    m = st_t.size();
    wr(REG_CONFIG, 8'h01);
    lows = 0;
    for (int i = 0; i < 300; i++)
    begin
      cycles(1);
      lows += (converting !== 1'b1);
    end
    chk("idle cycles", 0, lows);
    check_pass(m, 2 * NEN);
    wr(REG_RATE, 8'h00);
    cycles(LC + 100);
    m = st_t.size();
    lows = 0;
    for (int i = 0; i < 2 * LC; i++)
    begin
      cycles(1);
      lows += (converting === 1'b0);
    end
    for (int i = m; i < st_t.size(); i++)
      if (st_ch[i] === 3'h0)
        ft.push_back(st_t[i]);
    chk("shutdown seen", 1, lows > 0);
    chk("starts in two periods", 2 * NEN, st_t.size() - m);
    chk("pass period", LC, ft[1] - ft[0]);
    wr(REG_CONFIG, 8'h00);
    wait_idle();
    m = st_t.size();
    cycles(LC + 50);
    chk("starts after stop", m, st_t.size());
    rd(REG_DISABLE, 1, DIS);
    wr(REG_CONFIG, 8'h80);
    rd(REG_DISABLE, 1, DISABLE_RESET);
    rd(REG_CONFIG, 1, CFG_RESET);
    final_report();
  end
endmodule : msq_sequencer_tb
